// *** hdl/tbd_bus_decode.sv ***
// terminal controller glue: memory and port decode, interrupts, display word
//
// Summary of operation
// - memory request strobe enables the memory chip select decoder
// - read or write enable only while memory request and strobe present
// - port enable only while io request strobe is asserted
// - top address bits pick the entity, low bits pick the byte
// - program memory spans 32K in five jumper-selected layouts
// - data RAM decodes C000-C7FF for 2K or C000-DFFF for 8K
// - display RAM: two 2K banks, or one 8K bank pair 0-1FFF
// - data RAM split into key/switch region and scratch-pad region
// - display word is 16 bits, low seven bits hold the character code
// - other nine bits: graphic set, protect, size, five attributes
// - embedded mode ignores bits 12..8; pattern 01000 marks a delimiter
// - delimiter bits active high: half, underline, reverse, flash
// - delimiter bit 0 blanks the affected characters
// - maskable interrupt comes only from the serial controller causes
// - non-maskable interrupt from video timing vblank or line zero
// - processor clock runs at 3.6864 MHz
// - processor reset from power-up or power-down reset circuit
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tbd_map.svh"

module tbd_bus_decode
    import tbd_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16,
    parameter int DISP_W = 13
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // processor bus
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic memory_request_strobe,
    input wire logic io_request_strobe,
    input wire logic cpu_rd_strobe,
    input wire logic cpu_wr_strobe,
    // display buffer access
    input wire logic [DISP_W-1:0] disp_addr,
    input wire logic disp_strobe,
    // interrupt sources
    input wire logic serial_rx_full,
    input wire logic serial_tx_empty,
    input wire logic serial_ext_status,
    input wire logic video_vblank,
    input wire logic video_line_zero,
    // reset sources
    input wire logic power_up_reset,
    input wire logic power_down_reset,
    // register port
    input wire tbd_reg_idx_t reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // chip selects and enables
    output logic rom0_select,
    output logic rom1_select,
    output logic data_ram_select,
    output logic ram_scratch_region,
    output logic [1:0] disp_bank_select,
    output logic io_port_enable,
    output logic mem_read_enable,
    output logic mem_write_enable,
    // processor control
    output logic cpu_clk,
    output logic cpu_reset,
    output logic cpu_maskable_int,
    output logic cpu_nmi,
    output logic irq
);

    localparam int NCO_W = `TBD_NCO_W;
    localparam logic [NCO_W-1:0] NCO_INC = NCO_W'(`TBD_NCO_INC);

    function automatic logic in_range(
        input logic [15:0] a,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic is_delim(input logic [15:0] w);
        is_delim = ({w[15], w[14], w[7], w[6], w[5]} == `TBD_DELIM_PAT);
    endfunction

    logic [`TBD_CFG_W-1:0] cfg_q;
    logic [`TBD_NUM_EV-1:0] stat_q;
    logic [`TBD_NUM_EV-1:0] stat_d;
    logic [`TBD_NUM_EV-1:0] mask_q;
    logic [`TBD_NUM_EV-1:0] ev;
    logic [`TBD_NUM_EV-1:0] clr;
    logic [15:0] word_q;
    logic [NCO_W-1:0] nco_q;
    tbd_rom_cfg_e rom_cfg;
    logic [15:0] a16;
    logic [15:0] d16;
    logic rom0_d;
    logic rom1_d;
    logic ram_d;
    logic ram_hi_ok;
    logic [15:0] ram_hi;
    logic [1:0] disp_d;
    logic any_sel;
    logic wr_cfg;
    logic wr_stat;
    logic wr_mask;
    logic wr_word;
    logic embed;
    logic half_viol;
    logic w_delim;
    logic [4:0] attr;
    logic [DATA_W-1:0] rd_mux;

    assign a16 = 16'(cpu_addr);
    assign d16 = 16'(disp_addr);
    assign rom_cfg = tbd_rom_cfg_e'(cfg_q[`TBD_CFG_ROM_LSB +: 3]);
    assign embed = cfg_q[`TBD_CFG_EMBED];

    // register port decode
    assign wr_cfg = reg_wr && (reg_addr == `TBD_REG_CFG);
    assign wr_stat = reg_wr && (reg_addr == `TBD_REG_STAT);
    assign wr_mask = reg_wr && (reg_addr == `TBD_REG_MASK);
    assign wr_word = reg_wr && (reg_addr == `TBD_REG_WORD);

    // program memory decode
    always_comb begin
        rom0_d = 1'b0;
        rom1_d = 1'b0;
        unique case (rom_cfg)
            TBD_ROM_16K: begin
                rom0_d = in_range(a16, `TBD_ROM0_LO, `TBD_ROM0_HI);
            end
            TBD_ROM_20K: begin
                rom0_d = in_range(a16, `TBD_ROM0_LO, `TBD_ROM0_HI);
                rom1_d = in_range(a16, `TBD_ROM1_LO, `TBD_ROM1_4K_HI);
            end
            TBD_ROM_24K: begin
                rom0_d = in_range(a16, `TBD_ROM0_LO, `TBD_ROM0_HI);
                rom1_d = in_range(a16, `TBD_ROM1_LO, `TBD_ROM1_8K_HI);
            end
            TBD_ROM_32K_TWO: begin
                rom0_d = in_range(a16, `TBD_ROM0_LO, `TBD_ROM0_HI);
                rom1_d = in_range(a16, `TBD_ROM1_LO, `TBD_ROM_32K_HI);
            end
            TBD_ROM_32K_ONE: begin
                rom0_d = in_range(a16, `TBD_ROM0_LO, `TBD_ROM_32K_HI);
            end
            default: begin
                rom0_d = 1'b0;
            end
        endcase
    end

    // data RAM window by fitted size
    assign ram_hi = cfg_q[`TBD_CFG_RAM8K] ? `TBD_RAM_8K_HI : `TBD_RAM_2K_HI;
    assign ram_hi_ok = in_range(a16, `TBD_RAM_LO, ram_hi);
    assign ram_d = ram_hi_ok;

    // display bank decode
    always_comb begin
        disp_d = 2'b00;
        if (cfg_q[`TBD_CFG_DISP4]) begin
            disp_d[0] = in_range(d16, `TBD_DSP_LO, `TBD_DSP_4P_HI);
        end else begin
            disp_d[0] = in_range(d16, `TBD_DSP_LO, `TBD_DSP_B0_HI);
            disp_d[1] = in_range(d16, `TBD_DSP_B1_LO, `TBD_DSP_B1_HI);
        end
    end

    assign any_sel = rom0_d || rom1_d || ram_d;

    // registered selects, memory selects gated by memory request, display banks by display strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rom0_select <= 1'b0;
            rom1_select <= 1'b0;
            data_ram_select <= 1'b0;
            ram_scratch_region <= 1'b0;
        end else begin
            rom0_select <= memory_request_strobe && rom0_d;
            rom1_select <= memory_request_strobe && rom1_d;
            data_ram_select <= memory_request_strobe && ram_d;
            ram_scratch_region <= memory_request_strobe && ram_d
                && (a16 >= `TBD_RAM_SPLIT);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            disp_bank_select <= 2'b00;
        end else begin
            disp_bank_select <= disp_strobe ? disp_d : 2'b00;
        end
    end

    // transfer enables and port enable
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mem_read_enable <= 1'b0;
            mem_write_enable <= 1'b0;
            io_port_enable <= 1'b0;
        end else begin
            mem_read_enable <= memory_request_strobe && cpu_rd_strobe && any_sel;
            mem_write_enable <= memory_request_strobe && cpu_wr_strobe && any_sel;
            io_port_enable <= io_request_strobe && !memory_request_strobe;
        end
    end

    // processor clock from a phase accumulator
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            nco_q <= '0;
        end else begin
            nco_q <= nco_q + NCO_INC;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cpu_clk <= 1'b0;
        end else begin
            cpu_clk <= nco_q[NCO_W-1];
        end
    end

    // processor reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cpu_reset <= 1'b1;
        end else begin
            cpu_reset <= power_up_reset || power_down_reset;
        end
    end

    // processor interrupt lines
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cpu_maskable_int <= 1'b0;
            cpu_nmi <= 1'b0;
        end else begin
            cpu_maskable_int <= serial_rx_full || serial_tx_empty
                || serial_ext_status;
            cpu_nmi <= video_vblank || video_line_zero;
        end
    end

    // configuration and mask
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_q <= `TBD_CFG_RST;
        end else if (wr_cfg) begin
            cfg_q <= reg_wdata[`TBD_CFG_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mask_q <= '0;
        end else if (wr_mask) begin
            mask_q <= reg_wdata[`TBD_NUM_EV-1:0];
        end
    end

    // display word under inspection
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            word_q <= 16'h0000;
        end else if (wr_word) begin
            word_q <= 16'(reg_wdata);
        end
    end

    // half intensity in a delimiter is flagged in the alternate emulation
    assign half_viol = wr_word && embed && cfg_q[`TBD_CFG_ALT]
        && is_delim(16'(reg_wdata)) && reg_wdata[4];

    assign ev[`TBD_EV_RXF] = serial_rx_full;
    assign ev[`TBD_EV_TXE] = serial_tx_empty;
    assign ev[`TBD_EV_EXT] = serial_ext_status;
    assign ev[`TBD_EV_VBL] = video_vblank;
    assign ev[`TBD_EV_LZ] = video_line_zero;
    assign ev[`TBD_EV_HALF] = half_viol;
    assign clr = wr_stat ? reg_wdata[`TBD_NUM_EV-1:0] : '0;

    // sticky status: a new event wins over a clear
    for (genvar i = 0; i < `TBD_NUM_EV; i++) begin : g_stat
        assign stat_d[i] = ev[i] || (stat_q[i] && !clr[i]);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

    // character word decode
    assign w_delim = embed && is_delim(word_q);
    always_comb begin
        if (w_delim) begin
            attr = word_q[4:0];
        end else if (embed) begin
            attr = 5'h00;
        end else begin
            attr = word_q[`TBD_W_ATTR_LSB +: 5];
        end
    end

    // read mux, unmapped reads return zero
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr)
            `TBD_REG_CFG: rd_mux = DATA_W'(cfg_q);
            `TBD_REG_STAT: rd_mux = DATA_W'(stat_q);
            `TBD_REG_MASK: rd_mux = DATA_W'(mask_q);
            `TBD_REG_WORD: rd_mux = DATA_W'(word_q);
            `TBD_REG_FIELD: rd_mux = DATA_W'({w_delim,
                word_q[`TBD_W_SIZE], word_q[`TBD_W_PROT],
                word_q[`TBD_W_GRAPH], 1'b0, word_q[`TBD_W_ASCII_W-1:0]});
            `TBD_REG_ATTR: rd_mux = DATA_W'(attr);
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    property p_no_sel_idle;
        !memory_request_strobe |=> !(rom0_select || rom1_select || data_ram_select);
    endproperty
    a_no_sel_idle: assert property (p_no_sel_idle)
        else $error("memory select without memory request");

    property p_rd_en;
        mem_read_enable |-> $past(memory_request_strobe && cpu_rd_strobe);
    endproperty
    a_rd_en: assert property (p_rd_en)
        else $error("read enable without request and read strobe");

    property p_io_en;
        io_port_enable |-> $past(io_request_strobe) && !$past(memory_request_strobe);
    endproperty
    a_io_en: assert property (p_io_en)
        else $error("port enable without io request");

    property p_rom_low;
        memory_request_strobe && (cpu_addr <= `TBD_ROM0_HI)
            && (rom_cfg != TBD_ROM_32K_ONE) && (cfg_q[2:0] < 3'h5)
            && !wr_cfg |=> rom0_select && !rom1_select;
    endproperty
    a_rom_low: assert property (p_rom_low)
        else $error("low program window not on first device");

    property p_ram_win;
        memory_request_strobe && (cpu_addr[15:11] == 5'h18) |=> data_ram_select;
    endproperty
    a_ram_win: assert property (p_ram_win)
        else $error("data RAM window missed");

    property p_disp_b1;
        disp_strobe && !cfg_q[`TBD_CFG_DISP4] && !wr_cfg
            && (disp_addr[DISP_W-1:11] == 2'h1) |=> disp_bank_select == 2'b10;
    endproperty
    a_disp_b1: assert property (p_disp_b1)
        else $error("second display bank not selected");

    property p_onehot;
        $onehot0({rom0_select, rom1_select, data_ram_select});
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one memory select");

    property p_nmi;
        (video_vblank || video_line_zero) |=> cpu_nmi
            && (stat_q[`TBD_EV_VBL] || stat_q[`TBD_EV_LZ]);
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("video event did not reach the non-maskable line");

    property p_int;
        cpu_maskable_int |-> $past(serial_rx_full || serial_tx_empty || serial_ext_status);
    endproperty
    a_int: assert property (p_int)
        else $error("maskable interrupt without serial cause");

    property p_reset;
        (power_up_reset || power_down_reset) |=> cpu_reset;
    endproperty
    a_reset: assert property (p_reset)
        else $error("processor reset not raised");

    property p_delim;
        wr_word && embed && !wr_cfg && (reg_wdata[15:14] == 2'b01)
            && (reg_wdata[7:5] == 3'b000) |=> w_delim ##0 attr == word_q[4:0];
    endproperty
    a_delim: assert property (p_delim)
        else $error("attribute delimiter not recognised");

    property p_irq;
        (|(stat_q & mask_q)) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked status did not raise interrupt");

endmodule

`default_nettype wire

// *** hdl/tbd_map.svh ***
// register map, field positions, address windows and timing constants
`ifndef TBD_MAP_SVH
`define TBD_MAP_SVH

// register indices on the register port
`define TBD_REG_CFG 3'h0
`define TBD_REG_STAT 3'h1
`define TBD_REG_MASK 3'h2
`define TBD_REG_WORD 3'h3
`define TBD_REG_FIELD 3'h4
`define TBD_REG_ATTR 3'h5

// configuration register fields
`define TBD_CFG_ROM_LSB 0
`define TBD_CFG_RAM8K 3
`define TBD_CFG_DISP4 4
`define TBD_CFG_EMBED 5
`define TBD_CFG_ALT 6
`define TBD_CFG_W 7
`define TBD_CFG_RST 7'h00

// interrupt status bits
`define TBD_EV_RXF 0
`define TBD_EV_TXE 1
`define TBD_EV_EXT 2
`define TBD_EV_VBL 3
`define TBD_EV_LZ 4
`define TBD_EV_HALF 5
`define TBD_NUM_EV 6

// processor address windows
`define TBD_ROM0_LO 16'h0000
`define TBD_ROM0_HI 16'h3fff
`define TBD_ROM1_LO 16'h4000
`define TBD_ROM1_4K_HI 16'h4fff
`define TBD_ROM1_8K_HI 16'h5fff
`define TBD_ROM_32K_HI 16'h7fff
`define TBD_RAM_LO 16'hc000
`define TBD_RAM_2K_HI 16'hc7ff
`define TBD_RAM_8K_HI 16'hdfff
`define TBD_RAM_SPLIT 16'hc400

// display buffer windows
`define TBD_DSP_LO 16'h0000
`define TBD_DSP_B0_HI 16'h07ff
`define TBD_DSP_B1_LO 16'h0800
`define TBD_DSP_B1_HI 16'h0fff
`define TBD_DSP_4P_HI 16'h1fff

// display word layout
`define TBD_W_ASCII_W 7
`define TBD_W_ATTR_LSB 8
`define TBD_W_SIZE 13
`define TBD_W_PROT 14
`define TBD_W_GRAPH 15
`define TBD_DELIM_PAT 5'h08

// processor clock synthesis
`define TBD_REF_HZ 64'd25000000
`define TBD_CPU_HZ 64'd3686400
`define TBD_NCO_W 24
`define TBD_NCO_INC ((`TBD_CPU_HZ << `TBD_NCO_W) / `TBD_REF_HZ)

`endif

// *** hdl/tbd_pkg.sv ***
// types shared by the terminal bus decoder
package tbd_pkg;

    typedef enum logic [2:0] {
        TBD_ROM_16K = 3'h0,
        TBD_ROM_20K = 3'h1,
        TBD_ROM_24K = 3'h2,
        TBD_ROM_32K_TWO = 3'h3,
        TBD_ROM_32K_ONE = 3'h4
    } tbd_rom_cfg_e;

    typedef logic [2:0] tbd_reg_idx_t;

endpackage

// *** test/tbd_cpu_model.sv ***
// processor bus master model driving the memory and port request lines
`timescale 1ns/1ps
`default_nettype none
module tbd_cpu_model (
    // processor bus
    output var logic [15:0] cpu_addr,
    output var logic memory_request_strobe,
    output var logic io_request_strobe,
    output var logic cpu_rd_strobe,
    output var logic cpu_wr_strobe
);
    initial begin
        cpu_addr = 16'h0000;
        memory_request_strobe = 1'b0;
        io_request_strobe = 1'b0;
        cpu_rd_strobe = 1'b0;
        cpu_wr_strobe = 1'b0;
    end

    // called just after a rising edge; an idle bus shows the inverted last address
    task automatic drive(input logic [15:0] a, input logic m, input logic i,
                         input logic r, input logic w);
        cpu_addr <= (m || i) ? a : ~cpu_addr;
        memory_request_strobe <= m;
        io_request_strobe <= i;
        cpu_rd_strobe <= r && (m || i);
        cpu_wr_strobe <= w && !r && (m || i);
    endtask
endmodule
`default_nettype wire

// *** test/tbd_bus_decode_bench.sv ***
// self-checking bench for the terminal bus decoder
`timescale 1ns/1ps
`default_nettype none
module tbd_bus_decode_bench
    import tbd_pkg::*;
();
    typedef struct {int due; int kind; logic [15:0] v;} tbd_note_s;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] cpu_addr, reg_wdata, reg_rdata, ca, wd, w;
    logic memory_request_strobe, io_request_strobe, cpu_rd_strobe, cpu_wr_strobe;
    logic [12:0] disp_addr, da;
    logic disp_strobe, serial_rx_full, serial_tx_empty, serial_ext_status;
    logic video_vblank, video_line_zero, power_up_reset, power_down_reset, reg_wr, reg_rd;
    tbd_reg_idx_t reg_addr;
    logic rom0_select, rom1_select, data_ram_select, ram_scratch_region, io_port_enable;
    logic mem_read_enable, mem_write_enable, cpu_clk, cpu_reset, cpu_maskable_int;
    logic cpu_nmi, irq;
    logic [1:0] disp_bank_select;
    logic cm, ci, cr, cw, ds, pu, pd, rw, rr;
    logic [4:0] src;
    logic [2:0] ra;
    logic [6:0] cfg;
    logic [5:0] st, msk;
    logic [15:0] word;
    logic [31:0] r;
    logic [15:0] al [18] = '{16'h0000, 16'h3fff, 16'h4000, 16'h4fff, 16'h5000, 16'h5fff,
        16'h6000, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hc3ff, 16'hc400, 16'hc7ff,
        16'hc800, 16'hdfff, 16'he000, 16'hffff};
    logic [12:0] dl [6] = '{13'h0000, 13'h07ff, 13'h0800, 13'h0fff, 13'h1000, 13'h1fff};
    int cyc = 0;
    int num_errors = 0;
    int checks = 0;
    int rises = 0;
    tbd_note_s nq[$];

    tbd_cpu_model cpu (.cpu_addr, .memory_request_strobe, .io_request_strobe,
        .cpu_rd_strobe, .cpu_wr_strobe);

    tbd_bus_decode uut (.ref_clk, .srst, .cpu_addr, .memory_request_strobe,
        .io_request_strobe, .cpu_rd_strobe, .cpu_wr_strobe, .disp_addr, .disp_strobe,
        .serial_rx_full, .serial_tx_empty, .serial_ext_status, .video_vblank,
        .video_line_zero, .power_up_reset, .power_down_reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .rom0_select, .rom1_select, .data_ram_select,
        .ram_scratch_region, .disp_bank_select, .io_port_enable, .mem_read_enable,
        .mem_write_enable, .cpu_clk, .cpu_reset, .cpu_maskable_int, .cpu_nmi, .irq);

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic cmp_sel(input logic [15:0] e);
        chk("selects", e, {7'h00, disp_bank_select, rom0_select, rom1_select, data_ram_select,
            ram_scratch_region, io_port_enable, mem_read_enable, mem_write_enable});
        chk("one_select", 16'h0001,
            {15'h0000, $onehot0({rom0_select, rom1_select, data_ram_select})});
    endtask

    task automatic cmp_rd(input logic [15:0] e);
        chk("reg_rdata", e, reg_rdata);
    endtask

    task automatic cmp_ctl(input logic [15:0] e);
        chk("cpu_ctl", e, {13'h0000, cpu_nmi, cpu_maskable_int, cpu_reset});
    endtask

    task automatic cmp_irq(input logic [15:0] e);
        chk("irq", e, {15'h0000, irq});
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // selects are expected from the configuration before this cycle's register write
    function automatic logic [15:0] exp_sel();
        logic [2:0] rc;
        logic r0, r1, rm;
        rc = cfg[2:0];
        r0 = cm && rc <= 3'h4 && ca <= ((rc == 3'h4) ? 16'h7fff : 16'h3fff);
        r1 = cm && rc inside {3'h1, 3'h2, 3'h3} && ca >= 16'h4000
            && ca <= (rc == 3'h1 ? 16'h4fff : rc == 3'h2 ? 16'h5fff : 16'h7fff);
        rm = cm && ca >= 16'hc000 && ca <= (cfg[3] ? 16'hdfff : 16'hc7ff);
        return {7'h00, ds && !cfg[4] && da >= 13'h0800 && da <= 13'h0fff,
            ds && (cfg[4] || da <= 13'h07ff), r0, r1, rm, rm && ca >= 16'hc400,
            ci && !cm, cm && cr && (r0 || r1 || rm), cm && cw && (r0 || r1 || rm)};
    endfunction

    function automatic logic [15:0] exp_reg(input logic [2:0] a);
        logic dm;
        dm = {word[15:14], word[7:5]} == 5'b01000;
        case (a)
            3'h0: return {9'h000, cfg};
            3'h1: return {10'h000, st};
            3'h2: return {10'h000, msk};
            3'h3: return word;
            3'h4: return {4'h0, cfg[5] && dm, word[13], word[14], word[15], 1'b0,
                word[6:0]};
            3'h5: return {11'h000, !cfg[5] ? word[12:8] : dm ? word[4:0] : 5'h00};
            default: return 16'h0000;
        endcase
    endfunction

    task automatic note(input int k, input int d, input logic [15:0] v);
        // inputs driven now are sampled one edge later, results show after that edge
        nq.push_back('{cyc + d + 1, k, v});
    endtask

    // one bus cycle: drive every input, note every expected result, advance the model
    task automatic step();
        logic [5:0] ev;
        @(posedge ref_clk);
        cpu.drive(ca, cm, ci, cr, cw);
        disp_addr <= da;
        disp_strobe <= ds;
        {serial_ext_status, serial_tx_empty, serial_rx_full} <= src[2:0];
        {video_line_zero, video_vblank} <= src[4:3];
        power_up_reset <= pu;
        power_down_reset <= pd;
        reg_addr <= ra;
        reg_wdata <= wd;
        reg_wr <= rw;
        reg_rd <= rr;
        note(0, 1, exp_sel());
        note(1, 1, rr ? exp_reg(ra) : 16'h0000);
        ev = {rw && ra == 3'h3 && cfg[6:5] == 2'b11 && wd[4]
            && {wd[15:14], wd[7:5]} == 5'b01000, src[4:3], src[2:0]};
        if (rw && ra == 3'h0) cfg = wd[6:0];
        if (rw && ra == 3'h1) st = st & ~wd[5:0];
        if (rw && ra == 3'h2) msk = wd[5:0];
        if (rw && ra == 3'h3) word = wd;
        st = st | ev;
        note(2, 1, {13'h0000, |src[4:3], |src[2:0], pu || pd});
        note(3, 2, {15'h0000, |(st & msk)});
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        ra = a;
        wd = d;
        rw = 1'b1;
        step();
        rw = 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        ra = a;
        rr = 1'b1;
        step();
        rr = 1'b0;
    endtask

    task automatic rst(input int n);
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'b00;
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp_sel(16'h0000);
        cmp_ctl(16'h0001);
        cmp_irq(16'h0000);
        @(posedge ref_clk);
        srst <= 1'b0;
        cfg = 7'h00;
        st = 6'h00;
        msk = 6'h00;
        word = 16'h0000;
    endtask

    always @(negedge ref_clk) begin
        tbd_note_s n;
        while (nq.size() > 0 && nq[0].due <= cyc) begin
            n = nq.pop_front();
            if (n.kind == 0) cmp_sel(n.v);
            if (n.kind == 1) cmp_rd(n.v);
            if (n.kind == 2) cmp_ctl(n.v);
            if (n.kind == 3) cmp_irq(n.v);
        end
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    always @(posedge cpu_clk) rises++;

    initial begin
        {ca, cm, ci, cr, cw, da, ds, src, pu, pd, rw, rr, ra, wd} = '0;
        {disp_addr, disp_strobe, serial_rx_full, serial_tx_empty, serial_ext_status} = '0;
        {video_vblank, video_line_zero, power_up_reset, power_down_reset} = '0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {cfg, st, msk, word} = '0;
        void'($urandom(32'h60d3));
        rst(16);
        for (int i = 4; i < 8; i++) wr(i[2:0], 16'hffff);
        for (int i = 0; i < 8; i++) rd(i[2:0]);
        $display("test registers done");
        for (int c = 0; c < 32; c++) begin
            wr(3'h0, {11'h000, c[4:0]});
            for (int k = 0; k < 26; k++) begin
                r = $urandom;
                ca = (k < 18) ? al[k] : r[31:16];
                cm = r[0] || k < 18;
                ci = r[1];
                cr = r[2];
                cw = !r[2] && r[3];
                da = (k < 18) ? dl[k % 6] : r[17:5];
                ds = r[4] || k < 18;
                step();
            end
        end
        {cm, ci, cr, cw, ds} = '0;
        $display("test decode done");
        for (int md = 0; md < 4; md++) begin
            wr(3'h0, {9'h000, md[1:0], 5'h00});
            for (int k = 0; k < 12; k++) begin
                w = 16'($urandom);
                if (k[0]) w = {2'b01, w[13:8], 3'b000, w[4:0]};
                if (md == 3) w[4] = 1'b0;
                wr(3'h3, w);
                for (int i = 3; i < 6; i++) rd(i[2:0]);
            end
        end
        wr(3'h3, 16'h4010);
        repeat (2) step();
        rd(3'h1);
        wr(3'h1, 16'h003f);
        rd(3'h1);
        $display("test display word done");
        for (int s = 0; s < 5; s++) begin
            for (int mk = 0; mk < 2; mk++) begin
                wr(3'h2, mk ? 16'(1 << s) : 16'h0000);
                src = 5'(1 << s);
                wr(3'h1, 16'(1 << s));
                src = 5'h00;
                repeat (2) step();
                rd(3'h1);
                wr(3'h1, 16'(1 << s));
                rd(3'h1);
                rd(3'h2);
            end
        end
        for (int p = 1; p < 4; p++) begin
            {pd, pu} = p[1:0];
            step();
        end
        {pd, pu} = 2'b00;
        repeat (2) step();
        $display("test interrupts done");
        wr(3'h0, 16'h007f);
        rst(3);
        rd(3'h0);
        step();
        $display("test second reset done");
        @(negedge ref_clk);
        rises = 0;
        repeat (5000) @(negedge ref_clk);
        chk("cpu_clk_rises", 16'h0001, {15'h0000, rises >= 736 && rises <= 739});
        $display("test clock done");
        wrap_up();
    end
endmodule
`default_nettype wire
